// ===== inc/cpig_pkg.sv
// cpig_pkg: shared offsets, field positions and carriers of the irq gating
package cpig_pkg;

	// register offsets on the plain register port
	localparam logic [2:0] CPIG_OFS_INTCTL   = 3'h0;
	localparam logic [2:0] CPIG_OFS_PIE_ONE  = 3'h1;
	localparam logic [2:0] CPIG_OFS_PIE_TWO  = 3'h2;
	localparam logic [2:0] CPIG_OFS_PIR_ONE  = 3'h3;
	localparam logic [2:0] CPIG_OFS_PIR_TWO  = 3'h4;
	localparam logic [2:0] CPIG_OFS_OPTION   = 3'h5;
	localparam logic [2:0] CPIG_OFS_PIN_MASK = 3'h6;

	// interrupt_control fields
	localparam int CPIG_B_GIE  = 7;
	localparam int CPIG_B_PERIPHERAL_GROUP_ENABLE = 6;
	localparam int CPIG_B_T0EN = 5;
	localparam int CPIG_B_EXEN = 4;
	localparam int CPIG_B_PCEN = 3;
	localparam int CPIG_B_T0F  = 2;
	localparam int CPIG_B_EXF  = 1;
	localparam int CPIG_B_PCF  = 0;

	// peripheral enable / request one fields
	localparam int CPIG_B_T1G = 7;
	localparam int CPIG_B_ADC = 6;
	localparam int CPIG_B_LTB = 3;
	localparam int CPIG_B_LTA = 2;
	localparam int CPIG_B_T2  = 1;
	localparam int CPIG_B_T1  = 0;

	// peripheral enable / request two fields
	localparam int CPIG_B_CMPB = 5;
	localparam int CPIG_B_CMPA = 4;
	localparam int CPIG_B_OGEN = 2;
	localparam int CPIG_B_CCP  = 0;

	// option field: external pin edge select
	localparam int CPIG_B_EDGE = 6;

	// implemented bits and reset values
	localparam logic [7:0] CPIG_MASK_CORE = 8'hff;
	localparam logic [7:0] CPIG_MASK_ONE  = 8'hcf;
	localparam logic [7:0] CPIG_MASK_TWO  = 8'h35;
	localparam logic [7:0] CPIG_MASK_OPT  = 8'h40;
	localparam logic [7:0] CPIG_RST_REG   = 8'h00;
	localparam logic [7:0] CPIG_RST_OPT   = 8'h40;
	localparam logic [7:0] CPIG_RD_NONE   = 8'h00;

	typedef enum logic [1:0] {
		CPIG_CCP_CAPTURE,
		CPIG_CCP_COMPARE,
		CPIG_CCP_PWM
	} cpig_ccp_e;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} cpig_bus_s;

	typedef struct packed {
		logic      timer0Rollover;
		logic      timer1Gate;
		logic      adcDone;
		logic      limitTimerBMatch;
		logic      limitTimerAMatch;
		logic      timer2Match;
		logic      timer1Rollover;
		logic      outputGenShutdown;
		logic      captureEvent;
		logic      compareMatch;
		cpig_ccp_e ccpMode;
		logic      comparatorAOutput;
		logic      comparatorBOutput;
	} cpig_evt_s;

	typedef struct packed {
		logic prev;
		logic armed;
	} cpig_edge_s;

	typedef struct packed {
		logic [7:0] prev;
		logic       armed;
	} cpig_chg_s;

	typedef struct packed {
		logic [7:0] intCtl;
		logic [7:0] pieOne;
		logic [7:0] pieTwo;
		logic [7:0] pirOne;
		logic [7:0] pirTwo;
		logic [7:0] option;
		logic [7:0] pinMask;
		logic [1:0] cmpPrev;
		logic       cmpArmed;
		logic       irqReq;
		logic [7:0] rdData;
	} cpig_top_s;

endpackage

// ===== rtl/cpig_ext_edge.sv
// cpig_ext_edge: selectable edge detector for the external interrupt pin
`timescale 1ns/100ps
module cpig_ext_edge
	import cpig_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// pin and edge choice
	input  wire logic pinLevel,
	input  wire logic risingSel,
	// detected edge
	output logic      edgePulse
);

	cpig_edge_s st_r;
	cpig_edge_s st_nxt;

	always_comb begin
		st_nxt       = st_r;
		st_nxt.prev  = pinLevel;
		st_nxt.armed = 1'b1;
	end

	// no edge before a first sample exists
	assign edgePulse = st_r.armed & (risingSel ? (pinLevel & ~st_r.prev)
		: (~pinLevel & st_r.prev));

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule // cpig_ext_edge

// ===== rtl/cpig_pin_change.sv
// cpig_pin_change: per-pin masked change detector for pin_change_detect
`timescale 1ns/100ps
module cpig_pin_change
	import cpig_pkg::*;
#(
	parameter int NPINS = 6
)(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// monitored pins and per-pin enables
	input  wire logic [NPINS-1:0] pins,
	input  wire logic [NPINS-1:0] pinMask,
	// any enabled pin changed
	output logic                  changePulse
);

	cpig_chg_s  st_r;
	cpig_chg_s  st_nxt;
	logic [7:0] pinsWide;
	logic [7:0] maskWide;

	assign pinsWide = 8'(pins);
	assign maskWide = 8'(pinMask);

	always_comb begin
		st_nxt       = st_r;
		st_nxt.prev  = pinsWide;
		st_nxt.armed = 1'b1;
	end

	// only pins enabled one by one may report
	assign changePulse = st_r.armed & |((pinsWide ^ st_r.prev) & maskWide);

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule // cpig_pin_change

// ===== rtl/cpig_irq_gating.sv
// cpig_irq_gating: core and peripheral interrupt enables, flags and request
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/100ps
module cpig_irq_gating
	import cpig_pkg::*;
#(
	parameter int NPINS = 6
)(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// register port
	input  wire cpig_bus_s        busReq,
	output logic [7:0]            rdData,
	// peripheral event sources
	input  wire cpig_evt_s        evt,
	// pins
	input  wire logic             externalIrqPin,
	input  wire logic [NPINS-1:0] changePins,
	// request to the core
	output logic                  irqRequest
);

	////////////////////////////////////////////////////////////////////////////

	if (NPINS < 1 || NPINS > 8) begin : g_bad_npins
		$error("NPINS must lie between 1 and 8");
	end

	////////////////////////////////////////////////////////////////////////////

	// write through, then hardware set, limited to implemented bits
	function automatic logic [7:0] flagUpdate(
		input logic [7:0] cur,
		input logic       wrHit,
		input logic [7:0] wdata,
		input logic [7:0] setBits,
		input logic [7:0] implMask
	);
		logic [7:0] base;
		base = wrHit ? wdata : cur;
		return (base | setBits) & implMask;
	endfunction

	// plain read/write register, unimplemented bits forced low
	function automatic logic [7:0] regUpdate(
		input logic [7:0] cur,
		input logic       wrHit,
		input logic [7:0] wdata,
		input logic [7:0] implMask
	);
		return (wrHit ? wdata : cur) & implMask;
	endfunction

	////////////////////////////////////////////////////////////////////////////

	cpig_top_s  st_r;
	cpig_top_s  st_nxt;

	logic       extEdge;
	logic       pinChange;
	logic [1:0] cmpNow;
	logic [1:0] cmpChanged;
	logic       ccpEvent;
	logic [7:0] coreSet;
	logic [7:0] oneSet;
	logic [7:0] twoSet;
	logic       wrIntCtl;
	logic       wrPieOne;
	logic       wrPieTwo;
	logic       wrPirOne;
	logic       wrPirTwo;
	logic       wrOption;
	logic       wrPinMask;
	logic       coreHit;
	logic       periHit;
	logic [7:0] rdMux;

	////////////////////////////////////////////////////////////////////////////
	// event detectors

	cpig_ext_edge u_ext_edge (
		.clk       (clk),
		.rst       (rst),
		.pinLevel  (externalIrqPin),
		.risingSel (st_r.option[CPIG_B_EDGE]),
		.edgePulse (extEdge)
	);

	cpig_pin_change #(
		.NPINS (NPINS)
	) u_pin_change (
		.clk         (clk),
		.rst         (rst),
		.pins        (changePins),
		.pinMask     (st_r.pinMask[NPINS-1:0]),
		.changePulse (pinChange)
	);

	// comparator flags follow any change of either output
	assign cmpNow     = {evt.comparatorBOutput, evt.comparatorAOutput};
	assign cmpChanged = st_r.cmpArmed ? (cmpNow ^ st_r.cmpPrev) : 2'h0;

	// capture/compare source picked by mode, nothing in pwm
	always_comb begin
		case (evt.ccpMode)
			CPIG_CCP_CAPTURE: begin
				ccpEvent = evt.captureEvent;
			end
			CPIG_CCP_COMPARE: begin
				ccpEvent = evt.compareMatch;
			end
			default: begin
				ccpEvent = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// hardware set vectors, independent of any enable except the per-pin mask

	always_comb begin
		coreSet              = 8'h00;
		coreSet[CPIG_B_T0F]  = evt.timer0Rollover;
		coreSet[CPIG_B_EXF]  = extEdge;
		coreSet[CPIG_B_PCF]  = pinChange;
	end

	always_comb begin
		oneSet               = 8'h00;
		oneSet[CPIG_B_T1G]   = evt.timer1Gate;
		oneSet[CPIG_B_ADC]   = evt.adcDone;
		oneSet[CPIG_B_LTB]   = evt.limitTimerBMatch;
		oneSet[CPIG_B_LTA]   = evt.limitTimerAMatch;
		oneSet[CPIG_B_T2]    = evt.timer2Match;
		oneSet[CPIG_B_T1]    = evt.timer1Rollover;
	end

	always_comb begin
		twoSet               = 8'h00;
		twoSet[CPIG_B_CMPB]  = cmpChanged[1];
		twoSet[CPIG_B_CMPA]  = cmpChanged[0];
		twoSet[CPIG_B_OGEN]  = evt.outputGenShutdown;
		twoSet[CPIG_B_CCP]   = ccpEvent;
	end

	////////////////////////////////////////////////////////////////////////////
	// write decode

	always_comb begin
		wrIntCtl  = 1'b0;
		wrPieOne  = 1'b0;
		wrPieTwo  = 1'b0;
		wrPirOne  = 1'b0;
		wrPirTwo  = 1'b0;
		wrOption  = 1'b0;
		wrPinMask = 1'b0;
		if (!busReq.wr) begin
			wrIntCtl = 1'b0;
		end else if (busReq.addr == CPIG_OFS_INTCTL) begin
			wrIntCtl = 1'b1;
		end else if (busReq.addr == CPIG_OFS_PIE_ONE) begin
			wrPieOne = 1'b1;
		end else if (busReq.addr == CPIG_OFS_PIE_TWO) begin
			wrPieTwo = 1'b1;
		end else if (busReq.addr == CPIG_OFS_PIR_ONE) begin
			wrPirOne = 1'b1;
		end else if (busReq.addr == CPIG_OFS_PIR_TWO) begin
			wrPirTwo = 1'b1;
		end else if (busReq.addr == CPIG_OFS_OPTION) begin
			wrOption = 1'b1;
		end else if (busReq.addr == CPIG_OFS_PIN_MASK) begin
			wrPinMask = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read mux, unmapped offsets read zero

	always_comb begin
		rdMux = CPIG_RD_NONE;
		if (busReq.addr == CPIG_OFS_INTCTL) begin
			rdMux = st_r.intCtl;
		end else if (busReq.addr == CPIG_OFS_PIE_ONE) begin
			rdMux = st_r.pieOne;
		end else if (busReq.addr == CPIG_OFS_PIE_TWO) begin
			rdMux = st_r.pieTwo;
		end else if (busReq.addr == CPIG_OFS_PIR_ONE) begin
			rdMux = st_r.pirOne;
		end else if (busReq.addr == CPIG_OFS_PIR_TWO) begin
			rdMux = st_r.pirTwo;
		end else if (busReq.addr == CPIG_OFS_OPTION) begin
			rdMux = st_r.option;
		end else if (busReq.addr == CPIG_OFS_PIN_MASK) begin
			rdMux = st_r.pinMask;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// request gating on the registered enables and flags

	// core sources: enables sit three places above their flags
	assign coreHit = |((st_r.intCtl[CPIG_B_T0EN:CPIG_B_PCEN])
		& (st_r.intCtl[CPIG_B_T0F:CPIG_B_PCF]));

	// peripheral sources only with the group enable
	assign periHit = st_r.intCtl[CPIG_B_PERIPHERAL_GROUP_ENABLE]
		& (|(st_r.pieOne & st_r.pirOne) | |(st_r.pieTwo & st_r.pirTwo));

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_nxt = st_r;

		// set beats a software clear in the same cycle
		st_nxt.intCtl = flagUpdate(st_r.intCtl, wrIntCtl, busReq.wdata,
			coreSet, CPIG_MASK_CORE);
		st_nxt.pirOne = flagUpdate(st_r.pirOne, wrPirOne, busReq.wdata,
			oneSet, CPIG_MASK_ONE);
		st_nxt.pirTwo = flagUpdate(st_r.pirTwo, wrPirTwo, busReq.wdata,
			twoSet, CPIG_MASK_TWO);

		// enables, option and pin mask hold only implemented bits
		st_nxt.pieOne = regUpdate(st_r.pieOne, wrPieOne, busReq.wdata,
			CPIG_MASK_ONE);
		st_nxt.pieTwo = regUpdate(st_r.pieTwo, wrPieTwo, busReq.wdata,
			CPIG_MASK_TWO);
		st_nxt.option = regUpdate(st_r.option, wrOption, busReq.wdata,
			CPIG_MASK_OPT);
		st_nxt.pinMask = regUpdate(st_r.pinMask, wrPinMask, busReq.wdata,
			8'(2 ** NPINS - 1));

		// comparator history
		st_nxt.cmpPrev  = cmpNow;
		st_nxt.cmpArmed = 1'b1;

		st_nxt.irqReq = st_r.intCtl[CPIG_B_GIE] & (coreHit | periHit);

		// read data stands only in the cycle after the strobe
		st_nxt.rdData = busReq.rd ? rdMux : CPIG_RD_NONE;
	end

	////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r.intCtl   <= CPIG_RST_REG;
			st_r.pieOne   <= CPIG_RST_REG;
			st_r.pieTwo   <= CPIG_RST_REG;
			st_r.pirOne   <= CPIG_RST_REG;
			st_r.pirTwo   <= CPIG_RST_REG;
			st_r.option   <= CPIG_RST_OPT;
			st_r.pinMask  <= CPIG_RST_REG;
			st_r.cmpPrev  <= 2'h0;
			st_r.cmpArmed <= 1'b0;
			st_r.irqReq   <= 1'b0;
			st_r.rdData   <= CPIG_RD_NONE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdData     = st_r.rdData;
	assign irqRequest = st_r.irqReq;

endmodule // cpig_irq_gating

// ===== bench/cpig_irq_gating_chk.sv
// cpig_irq_gating_chk: port-level checks of the interrupt gating block
`timescale 1ns/100ps
module cpig_irq_gating_chk
	import cpig_pkg::*;
#(
	parameter int NPINS = 6
)(
	// clock and reset
	input wire logic             clk,
	input wire logic             rst,
	// register port
	input wire cpig_bus_s        busReq,
	input wire logic [7:0]       rdData,
	// events and pins
	input wire cpig_evt_s        evt,
	input wire logic             externalIrqPin,
	input wire logic [NPINS-1:0] changePins,
	// request to the core
	input wire logic             irqRequest
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	logic [7:0] ctlR;
	logic [7:0] pie1R;
	logic [7:0] optR;
	logic [1:0] live;

	////////////////////////////////////////////////////////////////////////
	// mirror of software-owned enables; flag bits of ctlR are not used
	always_ff @(posedge clk) begin
		if (rst) begin
			ctlR <= 8'h00;
			pie1R <= 8'h00;
			optR <= CPIG_RST_OPT;
			live <= 2'h0;
		end else begin
			if (live != 2'h3)
				live <= live + 2'h1;
			if (busReq.wr && busReq.addr == CPIG_OFS_INTCTL)
				ctlR <= busReq.wdata;
			if (busReq.wr && busReq.addr == CPIG_OFS_PIE_ONE)
				pie1R <= busReq.wdata;
			if (busReq.wr && busReq.addr == CPIG_OFS_OPTION)
				optR <= busReq.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	property p_reset;
		$fell(rst) |-> rdData == 8'h00 && !irqRequest;
	endproperty
	property p_one;
		busReq.rd && (busReq.addr == CPIG_OFS_PIE_ONE ||
			busReq.addr == CPIG_OFS_PIR_ONE) |=> (rdData & ~CPIG_MASK_ONE) == 8'h00;
	endproperty
	property p_two;
		busReq.rd && (busReq.addr == CPIG_OFS_PIE_TWO ||
			busReq.addr == CPIG_OFS_PIR_TWO) |=> (rdData & ~CPIG_MASK_TWO) == 8'h00;
	endproperty
	property p_gie;
		!ctlR[CPIG_B_GIE] |=> !irqRequest;
	endproperty
	property p_peripheral_group_enable;
		!ctlR[CPIG_B_PERIPHERAL_GROUP_ENABLE] && ctlR[5:3] == 3'h0 |=> !irqRequest;
	endproperty
	property p_t1req;
		(evt.timer1Rollover && !busReq.wr && ctlR[7:6] == 2'h3 && pie1R[0])
			##1 !busReq.wr |=> irqRequest;
	endproperty
	property p_ext;
		(live == 2'h3 && ctlR[CPIG_B_GIE] && ctlR[CPIG_B_EXEN] && !busReq.wr &&
			(optR[CPIG_B_EDGE] ? $rose(externalIrqPin) : $fell(externalIrqPin)))
			##1 !busReq.wr |=> irqRequest;
	endproperty
	property p_adc;
		evt.adcDone ##1 (busReq.rd && busReq.addr == CPIG_OFS_PIR_ONE)
			|=> rdData[CPIG_B_ADC];
	endproperty
	property p_cmp;
		(live == 2'h3 && $changed(evt.comparatorAOutput))
			##1 (busReq.rd && busReq.addr == CPIG_OFS_PIR_TWO) |=> rdData[CPIG_B_CMPA];
	endproperty

	a_reset: assert property (p_reset) else $error("reset not clean");
	a_one: assert property (p_one) else $error("reserved bit set");
	a_two: assert property (p_two) else $error("reserved bit set");
	a_gie: assert property (p_gie) else $error("request while off");
	a_peripheral_group_enable: assert property (p_peripheral_group_enable) else $error("group not off");
	a_t1req: assert property (p_t1req) else $error("no request");
	a_ext: assert property (p_ext) else $error("edge missed");
	a_adc: assert property (p_adc) else $error("adc flag missing");
	a_cmp: assert property (p_cmp) else $error("cmp flag missing");

	c_req: cover property (irqRequest && ctlR[7:6] == 2'h3);
	c_rise: cover property ($rose(irqRequest));
	c_rd2: cover property (busReq.rd && busReq.addr == CPIG_OFS_PIR_TWO);
endmodule // cpig_irq_gating_chk

bind cpig_irq_gating cpig_irq_gating_chk #(.NPINS(NPINS)) i_chk (
	.clk(clk), .rst(rst), .busReq(busReq), .rdData(rdData), .evt(evt),
	.externalIrqPin(externalIrqPin), .changePins(changePins),
	.irqRequest(irqRequest)
);

// ===== bench/cpig_evt_src.sv
// cpig_evt_src: behavioural peripheral event sources and pins
`timescale 1ns/100ps
module cpig_evt_src
	import cpig_pkg::*;
#(
	parameter int NPINS = 6
)(
	// clock
	input  wire logic             clk,
	// command from the bench
	input  wire logic             fire,
	input  wire logic [3:0]       fireSel,
	input  wire cpig_ccp_e        mode,
	// events and pins toward the block
	output cpig_evt_s             evt,
	output logic                  extPin,
	output logic [NPINS-1:0]      pins
);
	logic [9:0] pulse;

	assign pulse = 10'h200 >> fireSel;

	initial begin
		evt = '0;
		extPin = 1'b0;
		pins = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// one-cycle strobes; levels toggle on command
	always @(posedge clk) begin
		evt[13:4] <= fire ? pulse : 10'h000;
		evt.ccpMode <= mode;
		if (fire && fireSel == 4'ha)
			evt.comparatorAOutput <= !evt.comparatorAOutput;
		if (fire && fireSel == 4'hb)
			evt.comparatorBOutput <= !evt.comparatorBOutput;
		if (fire && fireSel == 4'hc)
			extPin <= !extPin;
		if (fire && fireSel == 4'hd)
			pins[0] <= !pins[0];
	end
endmodule // cpig_evt_src

// ===== bench/test_cpig_irq_gating.sv
// test_cpig_irq_gating: self-checking bench of the interrupt gating block
`timescale 1ns/100ps
module test_cpig_irq_gating
	import cpig_pkg::*;
;
	localparam int NPINS = 6;
	localparam logic [2:0] EV_ADDR [14] = '{3'h0, 3'h3, 3'h3, 3'h3, 3'h3,
		3'h3, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h0, 3'h0};
	localparam logic [7:0] EV_BIT [14] = '{8'h04, 8'h80, 8'h40, 8'h08, 8'h04,
		8'h02, 8'h01, 8'h04, 8'h01, 8'h01, 8'h10, 8'h20, 8'h02, 8'h01};

	logic             clk = 1'b0;
	logic             rst = 1'b1;
	cpig_bus_s        busReq = '0;
	logic [7:0]       rdData;
	cpig_evt_s        evt;
	logic             extPin;
	logic [NPINS-1:0] pins;
	logic             irqRequest;
	logic             fire = 1'b0;
	logic [3:0]       fireSel = 4'h0;
	cpig_ccp_e        mode = CPIG_CCP_CAPTURE;
	logic             rdSeen = 1'b0;
	logic [7:0]       expQ [$];
	logic [31:0]      lfsr = 32'h2ef3;
	int               mismatches = 0;
	int               checksDone = 0;

	always #5 clk = ~clk;

	cpig_irq_gating #(.NPINS(NPINS)) i_dut (
		.clk(clk), .rst(rst), .busReq(busReq), .rdData(rdData), .evt(evt),
		.externalIrqPin(extPin), .changePins(pins), .irqRequest(irqRequest)
	);
	cpig_evt_src #(.NPINS(NPINS)) i_src (
		.clk(clk), .fire(fire), .fireSel(fireSel), .mode(mode), .evt(evt),
		.extPin(extPin), .pins(pins)
	);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsrNext(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic testDone();
		$display("checks %0d mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic compare(input string n, input logic [7:0] e, input logic [7:0] g);
		checksDone++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		busReq <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk);
		busReq <= '0;
	endtask

	task automatic regWr(input logic [2:0] a, input logic [7:0] d);
		access(1'b1, a, d);
	endtask

	task automatic regRd(input logic [2:0] a, input logic [7:0] e);
		expQ.push_back(e);
		access(1'b0, a, 8'h00);
	endtask

	task automatic pulseEvt(input logic [3:0] s);
		@(posedge clk);
		fire <= 1'b1;
		fireSel <= s;
		@(posedge clk);
		fire <= 1'b0;
	endtask

	// request latency is fixed at two cycles
	task automatic waitIrq(input logic e);
		repeat (3) @(negedge clk);
		compare("irqRequest", {7'h00, e}, {7'h00, irqRequest});
	endtask

	////////////////////////////////////////////////////////////////////////
	// read data watcher
	always @(posedge clk) begin
		if (rdSeen)
			compare("rdData", expQ.pop_front(), rdData);
		rdSeen <= busReq.rd;
	end

	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		testDone();
	end

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a < 8; a++)
			regRd(3'(a), a == 5 ? CPIG_RST_OPT : 8'h00);
		$display("reset values done");
		for (int a = 1; a < 5; a++) begin
			lfsr = lfsrNext(lfsr);
			regWr(3'(a), lfsr[7:0]);
			regRd(3'(a), lfsr[7:0] & (a[0] ? CPIG_MASK_ONE : CPIG_MASK_TWO));
			regWr(3'(a), 8'h00);
		end
		$display("register access done");
		regWr(CPIG_OFS_PIN_MASK, 8'h01);
		for (int s = 0; s < 14; s++) begin
			mode <= (s == 9) ? CPIG_CCP_COMPARE : CPIG_CCP_CAPTURE;
			pulseEvt(4'(s));
			regRd(EV_ADDR[s], EV_BIT[s]);
			regWr(EV_ADDR[s], 8'h00);
		end
		mode <= CPIG_CCP_PWM;
		pulseEvt(4'h8);
		pulseEvt(4'h9);
		regRd(CPIG_OFS_PIR_TWO, 8'h00);
		$display("event flags done");
		regWr(CPIG_OFS_PIE_ONE, 8'h01);
		regWr(CPIG_OFS_INTCTL, 8'hc0);
		pulseEvt(4'h6);
		waitIrq(1'b1);
		regWr(CPIG_OFS_INTCTL, 8'h80);
		waitIrq(1'b0);
		regWr(CPIG_OFS_INTCTL, 8'h40);
		waitIrq(1'b0);
		regWr(CPIG_OFS_PIR_ONE, 8'h00);
		regWr(CPIG_OFS_INTCTL, 8'ha0);
		pulseEvt(4'h0);
		waitIrq(1'b1);
		regWr(CPIG_OFS_INTCTL, 8'ha0);
		waitIrq(1'b0);
		regWr(CPIG_OFS_PIE_TWO, 8'h10);
		regWr(CPIG_OFS_INTCTL, 8'hc0);
		pulseEvt(4'ha);
		waitIrq(1'b1);
		regWr(CPIG_OFS_PIR_TWO, 8'h00);
		waitIrq(1'b0);
		$display("request gating done");
		regWr(CPIG_OFS_OPTION, 8'h00);
		regWr(CPIG_OFS_INTCTL, 8'h90);
		pulseEvt(4'hc);
		waitIrq(1'b1);
		regWr(CPIG_OFS_INTCTL, 8'h90);
		pulseEvt(4'hc);
		regRd(CPIG_OFS_INTCTL, 8'h90);
		$display("edge select done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		regRd(CPIG_OFS_INTCTL, 8'h00);
		regRd(CPIG_OFS_OPTION, CPIG_RST_OPT);
		repeat (3) @(posedge clk);
		$display("second reset done");
		testDone();
	end
endmodule // test_cpig_irq_gating
